// file: verilog/serlink_pkg.sv
package serlink_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_VIDEO_CFG   = 8'h4F;
  localparam logic [7:0] ADDR_LINK_CTL    = 8'h5B;
  localparam logic [7:0] ADDR_PAT_STATIC  = 8'h64;
  localparam logic [7:0] ADDR_PAT_IDX     = 8'h66;
  localparam logic [7:0] ADDR_PAT_DATA    = 8'h67;
  localparam logic [7:0] ADDR_SCROLL_CTL  = 8'h68;
  localparam logic [7:0] ADDR_ORDER_BASE  = 8'h70;
  localparam logic [7:0] ADDR_STATUS      = 8'h7F;
  localparam logic [7:0] ADDR_REPEATER    = 8'hC2;

  // Field positions
  localparam int BIT_MAP_SEL    = 7;
  localparam int BIT_PIX_MODE   = 6;
  localparam int BIT_REPEATER   = 5;
  localparam int BIT_CABLE      = 7;
  localparam int BIT_AUTO_OFF   = 2;
  localparam int BIT_FORCE_DUAL = 0;
  localparam int BIT_SCROLL_EN  = 0;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_PREV = 6'h3F;

  // Timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int CLK_MHZ          = 20;
  localparam int STRAP_SETTLE_NS  = 1000;
  localparam int STRAP_SETTLE_CYC =
    (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MEAS_WINDOW_CYC  = 4096;
  localparam int PCLK_DIV         = 32;
  localparam int LEGACY_MAX_MHZ   = 85;
  localparam int SINGLE_MAX_MHZ   = 96;
  localparam int EDGES_LEGACY =
    LEGACY_MAX_MHZ * MEAS_WINDOW_CYC / (CLK_MHZ * PCLK_DIV);
  localparam int EDGES_SINGLE =
    SINGLE_MAX_MHZ * MEAS_WINDOW_CYC / (CLK_MHZ * PCLK_DIV);

  // Sizes
  localparam int SCROLL_MAX = 16;
  localparam int ORDER_REGS = 8;
  localparam int PAT_DEPTH  = 32;

  localparam logic [1:0] RANGE_LOW  = 2'h0;
  localparam logic [1:0] RANGE_MID  = 2'h1;
  localparam logic [1:0] RANGE_HIGH = 2'h2;

  typedef enum logic [3:0] {
    MODE_SINGLE    = 4'h1,
    MODE_DUAL      = 4'h2,
    MODE_REPLICATE = 4'h4,
    MODE_SECONDARY = 4'h8
  } link_mode_t;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'h1,
    ST_LOAD   = 3'h2,
    ST_RUN    = 3'h4
  } strap_state_t;

endpackage

// file: verilog/strap_capture.sv
`timescale 1ns/100ps
module strap_capture (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic [2:0] level_pin,
  output logic      [2:0] level_reg
);

  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] level_next;

  // Level counts only once second and third stage agree
  always_comb
  begin
    level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg    <= 3'h0;
      s2_reg    <= 3'h0;
      s3_reg    <= 3'h0;
      level_reg <= 3'h0;
    end
    else if (ce)
    begin
      s1_reg    <= level_pin;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

endmodule

// file: verilog/pattern_mem.sv
`timescale 1ns/100ps
module pattern_mem (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       wr_en,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata_reg
);

  logic [7:0] mem [serlink_pkg::PAT_DEPTH];
  logic [7:0] rdata_next;

  always_comb
  begin
    rdata_next = mem[addr];
  end

  always_ff @(posedge clk_sys)
  begin
    if (ce && wr_en)
    begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_reg <= 8'h00;
    end
    else if (ce)
    begin
      rdata_reg <= rdata_next;
    end
  end

endmodule

// file: verilog/serializer_link_mode_config.sv
// Function
// [R1] Auto-scroll cycles through up to 16 programmed entries, repeats allowed.
// [R2] Scroll control and eight order registers drive scrolling; else static pattern.
// [R3] Indirect window: index at 0x66, data read and written at 0x67.
// [R4] Two multi-level straps are sampled at power-up into config bits.
// [R5] Software can read and overwrite every strap-derived bit afterwards.
// [R6] Pixel-mode strap stored inverted in 0x4F bit 6.
// [R7] Repeater strap stored unchanged in 0xC2 bit 5.
// [R8] Bit-mapping strap stored in 0x4F bit 7.
// [R9] Cable-type strap stored in 0x5B bit 7.
// [R10] Single link carries all video, up to 96 MHz, legacy below 85.
// [R11] Forced single powers down secondary transmitter and its back channel.
// [R12] Dual link sends alternate pixels on two links at half rate.
// [R13] Dual link with protection uses one session across both links.
// [R14] Dual-link receiver must recombine both alternating-pixel streams.
// [R15] Dual entered automatically on dual receiver and fast video, or forced.
// [R16] Replicate mode: second protection core, identical video up to 85 MHz.
// [R17] Measured pixel clock plus receiver capability choose the mode.
// [R18] Two independent single receivers give replicate mode.
// [R19] Receiver only on secondary link gives secondary-only transmission.
// [R20] Software can disable auto-detection and apply forced single or dual.
// [R21] Auto mode re-evaluated on link detect or clock range change.
`timescale 1ns/100ps
module serializer_link_mode_config (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic [2:0] mode_sel0_level,
  input  wire logic [2:0] mode_sel1_level,
  input  wire logic       pclk_div,
  input  wire logic       link0_detect,
  input  wire logic       link1_detect,
  input  wire logic       rx_dual_capable,
  input  wire logic       frame_start,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic      [3:0] link_mode,
  output logic            tx1_power_down,
  output logic            bc1_disable,
  output logic            tx_half_rate,
  output logic            cipher_joint_session,
  output logic            cipher_second_core_en,
  output logic            link0_video_en,
  output logic            link1_video_en,
  output logic      [3:0] pattern_sel,
  output logic            dual_pixel_mode,
  output logic            repeater_en,
  output logic            bit_map_sel,
  output logic            cable_cable_type_strap,
  output logic            strap_done
);

  logic [2:0] sel0_level;
  logic [2:0] sel1_level;
  logic [7:0] pat_rdata;

  strap_capture u_strap0 (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ce        (ce),
    .level_pin (mode_sel0_level),
    .level_reg (sel0_level)
  );

  strap_capture u_strap1 (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ce        (ce),
    .level_pin (mode_sel1_level),
    .level_reg (sel1_level)
  );

  // Strap load sequence
  serlink_pkg::strap_state_t state_reg;
  serlink_pkg::strap_state_t state_next;
  logic [4:0]                settle_reg;
  logic [4:0]                settle_next;

  always_comb
  begin
    state_next  = state_reg;
    settle_next = settle_reg;
    unique case (state_reg)
      serlink_pkg::ST_SETTLE:
      begin
        settle_next = settle_reg + 5'h1;
        if (settle_reg == 5'(serlink_pkg::STRAP_SETTLE_CYC - 1))
        begin
          state_next = serlink_pkg::ST_LOAD;
        end
      end
      serlink_pkg::ST_LOAD:
        state_next = serlink_pkg::ST_RUN;
      serlink_pkg::ST_RUN:
        state_next = serlink_pkg::ST_RUN;
      default:
        state_next = serlink_pkg::ST_SETTLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg  <= serlink_pkg::ST_SETTLE;
      settle_reg <= 5'h0;
    end
    else if (ce)
    begin
      state_reg  <= state_next;
      settle_reg <= settle_next;
    end
  end

  // Register file
  logic [7:0] video_cfg_reg;
  logic [7:0] video_cfg_next;
  logic [7:0] link_ctl_reg;
  logic [7:0] link_ctl_next;
  logic [7:0] repeater_reg;
  logic [7:0] repeater_next;
  logic [7:0] pat_idx_reg;
  logic [7:0] pat_idx_next;
  logic [7:0] pat_static_reg;
  logic [7:0] pat_static_next;
  logic [7:0] scroll_ctl_reg;
  logic [7:0] scroll_ctl_next;
  logic [7:0] order_reg [serlink_pkg::ORDER_REGS];
  logic       wr_video;
  logic       wr_link;
  logic       wr_rep;

  always_comb
  begin
    wr_video        = reg_wr && (reg_addr == serlink_pkg::ADDR_VIDEO_CFG);
    wr_link         = reg_wr && (reg_addr == serlink_pkg::ADDR_LINK_CTL);
    wr_rep          = reg_wr && (reg_addr == serlink_pkg::ADDR_REPEATER);
    video_cfg_next  = wr_video ? reg_wdata : video_cfg_reg;         // [R5]
    link_ctl_next   = wr_link ? reg_wdata : link_ctl_reg;           // [R5]
    repeater_next   = wr_rep ? reg_wdata : repeater_reg;            // [R5]
    pat_idx_next    = (reg_wr && reg_addr == serlink_pkg::ADDR_PAT_IDX) ?
                      reg_wdata : pat_idx_reg;                      // [R3]
    pat_static_next = (reg_wr && reg_addr == serlink_pkg::ADDR_PAT_STATIC) ?
                      reg_wdata : pat_static_reg;
    scroll_ctl_next = (reg_wr && reg_addr == serlink_pkg::ADDR_SCROLL_CTL) ?
                      reg_wdata : scroll_ctl_reg;                   // [R2]
    // Strap capture wins over a write in the load cycle
    if (state_reg == serlink_pkg::ST_LOAD)
    begin
      video_cfg_next[serlink_pkg::BIT_PIX_MODE] = ~sel0_level[2];  // [R4] [R6]
      repeater_next[serlink_pkg::BIT_REPEATER]  = sel0_level[0];   // [R7]
      video_cfg_next[serlink_pkg::BIT_MAP_SEL]  = sel1_level[2];   // [R8]
      link_ctl_next[serlink_pkg::BIT_CABLE]     = sel1_level[1];   // [R9]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      video_cfg_reg  <= serlink_pkg::RST_BYTE;
      link_ctl_reg   <= serlink_pkg::RST_BYTE;
      repeater_reg   <= serlink_pkg::RST_BYTE;
      pat_idx_reg    <= serlink_pkg::RST_BYTE;
      pat_static_reg <= serlink_pkg::RST_BYTE;
      scroll_ctl_reg <= serlink_pkg::RST_BYTE;
    end
    else if (ce)
    begin
      video_cfg_reg  <= video_cfg_next;
      link_ctl_reg   <= link_ctl_next;
      repeater_reg   <= repeater_next;
      pat_idx_reg    <= pat_idx_next;
      pat_static_reg <= pat_static_next;
      scroll_ctl_reg <= scroll_ctl_next;
    end
  end

  for (genvar g = 0; g < serlink_pkg::ORDER_REGS; g++)
  begin : g_order
    logic [7:0] order_next;
    always_comb
    begin
      order_next = (reg_wr && reg_addr == 8'(serlink_pkg::ADDR_ORDER_BASE + g)) ?
                   reg_wdata : order_reg[g];                        // [R2]
    end
    always_ff @(posedge clk_sys or negedge nrst)
    begin
      if (!nrst)
      begin
        order_reg[g] <= serlink_pkg::RST_BYTE;
      end
      else if (ce)
      begin
        order_reg[g] <= order_next;
      end
    end
  end

  pattern_mem u_pat_mem (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ce        (ce),
    .wr_en     (reg_wr && reg_addr == serlink_pkg::ADDR_PAT_DATA), // [R3]
    .addr      (pat_idx_reg[4:0]),
    .wdata     (reg_wdata),
    .rdata_reg (pat_rdata)
  );

  // Pixel clock measurement over a fixed window
  logic [2:0]  pc_sync_reg;
  logic        pc_lvl_reg;
  logic        pc_lvl_next;
  logic [11:0] win_reg;
  logic [10:0] edges_reg;
  logic [10:0] edges_next;
  logic [1:0]  range_reg;
  logic [1:0]  range_next;
  logic        win_end;

  always_comb
  begin
    pc_lvl_next = (pc_sync_reg[1] == pc_sync_reg[2]) ? pc_sync_reg[2] : pc_lvl_reg;
    win_end     = (win_reg == 12'(serlink_pkg::MEAS_WINDOW_CYC - 1));
    edges_next  = edges_reg + {10'h0, pc_lvl_next & ~pc_lvl_reg};
    range_next  = range_reg;
    if (win_end)
    begin
      edges_next = 11'h0;
      if (edges_reg > 11'(serlink_pkg::EDGES_SINGLE))               // [R17]
        range_next = serlink_pkg::RANGE_HIGH;
      else if (edges_reg > 11'(serlink_pkg::EDGES_LEGACY))
        range_next = serlink_pkg::RANGE_MID;
      else
        range_next = serlink_pkg::RANGE_LOW;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pc_sync_reg <= 3'h0;
      pc_lvl_reg  <= 1'b0;
      win_reg     <= 12'h0;
      edges_reg   <= 11'h0;
      range_reg   <= serlink_pkg::RANGE_LOW;
    end
    else if (ce)
    begin
      pc_sync_reg <= {pc_sync_reg[1:0], pclk_div};
      pc_lvl_reg  <= pc_lvl_next;
      win_reg     <= win_reg + 12'h1;
      edges_reg   <= edges_next;
      range_reg   <= range_next;
    end
  end

  // Link mode selection
  serlink_pkg::link_mode_t mode_reg;
  serlink_pkg::link_mode_t mode_next;
  serlink_pkg::link_mode_t auto_mode;
  logic [5:0] prev_reg;
  logic [5:0] prev_next;
  logic       auto_off;
  logic       force_dual;

  always_comb
  begin
    auto_off   = link_ctl_reg[serlink_pkg::BIT_AUTO_OFF];
    force_dual = link_ctl_reg[serlink_pkg::BIT_FORCE_DUAL];
    prev_next  = prev_reg;
    mode_next  = mode_reg;
    auto_mode  = serlink_pkg::MODE_SINGLE;                          // [R10]
    if (link0_detect && link1_detect)
    begin
      if (!rx_dual_capable)
        auto_mode = serlink_pkg::MODE_REPLICATE;                    // [R18]
      else if (range_reg == serlink_pkg::RANGE_HIGH)
        auto_mode = serlink_pkg::MODE_DUAL;                         // [R15] [R14]
    end
    else if (link1_detect)
    begin
      auto_mode = serlink_pkg::MODE_SECONDARY;                      // [R19]
    end
    if (state_reg == serlink_pkg::ST_RUN)
    begin
      prev_next = {auto_off, link0_detect, link1_detect, rx_dual_capable, range_reg};
      if (auto_off)
        mode_next = force_dual ? serlink_pkg::MODE_DUAL : serlink_pkg::MODE_SINGLE; // [R20]
      else if (prev_next != prev_reg)
        mode_next = auto_mode;                                      // [R21]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_reg              <= serlink_pkg::MODE_SINGLE;
      prev_reg              <= serlink_pkg::RST_PREV;
      link_mode             <= 4'h1;
      tx1_power_down        <= 1'b0;
      bc1_disable           <= 1'b0;
      tx_half_rate          <= 1'b0;
      cipher_joint_session  <= 1'b0;
      cipher_second_core_en <= 1'b0;
      link0_video_en        <= 1'b0;
      link1_video_en        <= 1'b0;
    end
    else if (ce)
    begin
      mode_reg              <= mode_next;
      prev_reg              <= prev_next;
      link_mode             <= mode_next;
      tx1_power_down        <= auto_off && mode_next == serlink_pkg::MODE_SINGLE; // [R11]
      bc1_disable           <= auto_off && mode_next == serlink_pkg::MODE_SINGLE; // [R11]
      tx_half_rate          <= mode_next == serlink_pkg::MODE_DUAL;      // [R12]
      cipher_joint_session  <= mode_next == serlink_pkg::MODE_DUAL;      // [R13]
      cipher_second_core_en <= mode_next == serlink_pkg::MODE_REPLICATE; // [R16]
      link0_video_en        <= mode_next != serlink_pkg::MODE_SECONDARY;
      link1_video_en        <= mode_next != serlink_pkg::MODE_SINGLE;    // [R12]
    end
  end

  // Pattern selection and auto-scroll
  logic [3:0] pos_reg;
  logic [3:0] pos_next;
  logic [3:0] pat_next;
  logic [7:0] order_cur;
  logic       scroll_en;

  always_comb
  begin
    scroll_en = scroll_ctl_reg[serlink_pkg::BIT_SCROLL_EN];
    order_cur = order_reg[pos_reg[3:1]];
    pos_next  = 4'h0;
    if (scroll_en)
    begin
      pos_next = pos_reg;
      if (frame_start)
        pos_next = (pos_reg == scroll_ctl_reg[7:4]) ? 4'h0 : pos_reg + 4'h1; // [R1]
    end
    pat_next = scroll_en ? (pos_reg[0] ? order_cur[7:4] : order_cur[3:0]) // [R2]
                         : pat_static_reg[3:0];
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pos_reg     <= 4'h0;
      pattern_sel <= 4'h0;
    end
    else if (ce)
    begin
      pos_reg     <= pos_next;
      pattern_sel <= pat_next;
    end
  end

  // Read port and configuration outputs
  logic [7:0] rdata_next;
  logic       overspeed;

  always_comb
  begin
    overspeed = (mode_reg == serlink_pkg::MODE_SINGLE && range_reg == serlink_pkg::RANGE_HIGH)
             || (mode_reg == serlink_pkg::MODE_REPLICATE && range_reg != serlink_pkg::RANGE_LOW);
    rdata_next = 8'h00;
    if (reg_addr[7:3] == serlink_pkg::ADDR_ORDER_BASE[7:3])
      rdata_next = order_reg[reg_addr[2:0]];
    else
      case (reg_addr)
        serlink_pkg::ADDR_VIDEO_CFG:  rdata_next = video_cfg_reg;   // [R5]
        serlink_pkg::ADDR_LINK_CTL:   rdata_next = link_ctl_reg;
        serlink_pkg::ADDR_REPEATER:   rdata_next = repeater_reg;
        serlink_pkg::ADDR_PAT_STATIC: rdata_next = pat_static_reg;
        serlink_pkg::ADDR_PAT_IDX:    rdata_next = pat_idx_reg;
        serlink_pkg::ADDR_PAT_DATA:   rdata_next = pat_rdata;       // [R3]
        serlink_pkg::ADDR_SCROLL_CTL: rdata_next = scroll_ctl_reg;
        serlink_pkg::ADDR_STATUS:     rdata_next = {overspeed, 1'b0, range_reg, mode_reg};
        default:                      rdata_next = 8'h00;
      endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata       <= 8'h00;
      reg_rvalid      <= 1'b0;
      dual_pixel_mode <= 1'b0;
      repeater_en     <= 1'b0;
      bit_map_sel     <= 1'b0;
      cable_cable_type_strap      <= 1'b0;
      strap_done      <= 1'b0;
    end
    else if (ce)
    begin
      reg_rdata       <= reg_rd ? rdata_next : reg_rdata;
      reg_rvalid      <= reg_rd;
      dual_pixel_mode <= ~video_cfg_reg[serlink_pkg::BIT_PIX_MODE];
      repeater_en     <= repeater_reg[serlink_pkg::BIT_REPEATER];
      bit_map_sel     <= video_cfg_reg[serlink_pkg::BIT_MAP_SEL];
      cable_cable_type_strap      <= link_ctl_reg[serlink_pkg::BIT_CABLE];
      strap_done      <= state_reg == serlink_pkg::ST_RUN;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_pix_invert: assert property (ce && state_reg == serlink_pkg::ST_LOAD |=> // [R6]
    video_cfg_reg[6] == !$past(sel0_level[2]) ##2 dual_pixel_mode == $past(sel0_level[2], 3))
    else $error("pixel mode strap not stored inverted");
  a_rep_latch: assert property (ce && state_reg == serlink_pkg::ST_LOAD |=> // [R7]
    repeater_reg[5] == $past(sel0_level[0]))
    else $error("repeater strap not latched");
  a_map_latch: assert property (ce && state_reg == serlink_pkg::ST_LOAD |=> // [R8]
    video_cfg_reg[7] == $past(sel1_level[2]))
    else $error("bit map strap not latched");
  a_cable_latch: assert property (ce && state_reg == serlink_pkg::ST_LOAD |=> // [R9]
    link_ctl_reg[7] == $past(sel1_level[1]))
    else $error("cable strap not latched");
  a_strap_once: assert property (state_reg == serlink_pkg::ST_RUN && !reg_wr |=> // [R4]
    $stable(video_cfg_reg) && $stable(repeater_reg) && $stable(link_ctl_reg))
    else $error("strap bits changed without a write");
  a_cfg_write: assert property (ce && wr_video && state_reg == serlink_pkg::ST_RUN |=> // [R5]
    video_cfg_reg == $past(reg_wdata))
    else $error("config write lost");
  a_indirect_rd: assert property (ce && reg_rd && reg_addr == serlink_pkg::ADDR_PAT_DATA |=> // [R3]
    reg_rvalid && reg_rdata == $past(pat_rdata))
    else $error("indirect data read wrong");
  a_force_single: assert property (ce && auto_off && !force_dual && state_reg == serlink_pkg::ST_RUN
    |=> tx1_power_down && bc1_disable && link_mode == 4'h1) // [R11]
    else $error("forced single did not power down secondary");
  a_force_dual: assert property (ce && auto_off && force_dual && state_reg == serlink_pkg::ST_RUN
    |=> link_mode == 4'h2 && tx_half_rate && cipher_joint_session) // [R12] [R13] [R20]
    else $error("forced dual not applied");
  a_replicate_auto: assert property ((ce && state_reg == serlink_pkg::ST_RUN && !auto_off // [R18]
    && link0_detect && link1_detect && !rx_dual_capable)[*3]
    |-> link_mode == 4'h4 && cipher_second_core_en && link0_video_en && link1_video_en) // [R16]
    else $error("replicate not selected");
  a_secondary_only: assert property ((ce && state_reg == serlink_pkg::ST_RUN && !auto_off // [R19]
    && !link0_detect && link1_detect)[*3] |-> link_mode == 4'h8 && !link0_video_en)
    else $error("secondary-only not selected");
  a_scroll_wrap: assert property (ce && scroll_en && frame_start // [R1]
    && pos_reg == scroll_ctl_reg[7:4] |=> pos_reg == 4'h0)
    else $error("scroll did not wrap");
  a_range_high: assert property (ce && win_end && edges_reg > 11'(serlink_pkg::EDGES_SINGLE) // [R17]
    |=> range_reg == serlink_pkg::RANGE_HIGH)
    else $error("clock range misclassified");

  c_dual: cover property (link_mode == 4'h2);
  c_replicate: cover property (link_mode == 4'h4);
  c_secondary: cover property (link_mode == 4'h8);
  c_scroll_wrap: cover property (scroll_en && frame_start && pos_reg == scroll_ctl_reg[7:4]);

endmodule

// file: verification/downstream_rx_model.sv
`timescale 1ns/100ps
module downstream_rx_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [1:0] attach,
  input  wire logic       dual_rx,
  output logic            link0_detect,
  output logic            link1_detect,
  output logic            rx_dual_capable
);
  // A dual receiver spans both links, so it only reports with both attached
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      link0_detect    <= 1'b0;
      link1_detect    <= 1'b0;
      rx_dual_capable <= 1'b0;
    end
    else
    begin
      link0_detect    <= attach[0];
      link1_detect    <= attach[1];
      rx_dual_capable <= dual_rx & (&attach);
    end
  end
endmodule

// file: verification/serializer_link_mode_config_tb.sv
`timescale 1ns/100ps
module serializer_link_mode_config_tb;
  logic       clk_sys, nrst, ce, pclk_div, pclk_run, frame_start, dual_rx;
  logic [2:0] sel0, sel1;
  logic [1:0] pdiv_cnt, attach;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, d;
  logic       reg_wr, reg_rd, reg_rvalid, link0_detect, link1_detect, rx_dual_capable;
  logic [3:0] link_mode, pattern_sel;
  logic       tx1_power_down, bc1_disable, tx_half_rate, cipher_joint_session;
  logic       cipher_second_core_en, link0_video_en, link1_video_en, strap_done;
  logic       dual_pixel_mode, repeater_en, bit_map_sel, cable_cable_type_strap;
  logic [31:0] seed;
  logic [3:0]  ent [16];
  int          errors, n_checks;

  serializer_link_mode_config u_dut (
    .clk_sys, .nrst, .ce, .mode_sel0_level(sel0), .mode_sel1_level(sel1),
    .pclk_div, .link0_detect, .link1_detect, .rx_dual_capable, .frame_start,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .link_mode,
    .tx1_power_down, .bc1_disable, .tx_half_rate, .cipher_joint_session,
    .cipher_second_core_en, .link0_video_en, .link1_video_en, .pattern_sel,
    .dual_pixel_mode, .repeater_en, .bit_map_sel, .cable_cable_type_strap, .strap_done
  );
  downstream_rx_model u_rx (
    .clk_sys, .nrst, .attach, .dual_rx, .link0_detect, .link1_detect, .rx_dual_capable
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Pixel clock stand-in toggles every third cycle, well above the single-link limit
  always @(negedge clk_sys)
  begin
    if (!nrst)
    begin
      pdiv_cnt <= 2'h0;
      pclk_div <= 1'b0;
    end
    else if (pclk_run)
    begin
      pdiv_cnt <= (pdiv_cnt == 2'h2) ? 2'h0 : pdiv_cnt + 2'h1;
      if (pdiv_cnt == 2'h2)
        pclk_div <= ~pclk_div;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [3:0] exp_mode(input logic a, input logic b, input logic c,
                                          input logic h);
    if (a && b)
      return !c ? 4'h4 : (h ? 4'h2 : 4'h1);
    return (b && !a) ? 4'h8 : 4'h1;
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    int i;
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
      cyc(1);
    if (i == 4)
    begin
      errors++;
      end_of_test();
    end
    v = reg_rdata;
    cyc(1);
  endtask

  task automatic auto(input logic [1:0] at, input logic c, input logic h);
    attach = at;
    dual_rx = c;
    cyc(6);
    chk("link_mode", {4'h0, exp_mode(at[0], at[1], c, h)}, {4'h0, link_mode});
  endtask

  initial
  begin
    seed = xs(32'h11FF);
    {sel1, sel0} = seed[5:0];
    {nrst, pclk_run, attach, dual_rx, frame_start} = '0;
    ce = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, errors, n_checks} = '0;
    cyc(20);
    nrst = 1'b1;
    for (int i = 0; i < 40 && strap_done !== 1'b1; i++)
      cyc(1);
    if (strap_done !== 1'b1)
    begin
      errors++;
      end_of_test();
    end
    chk("strap_done", 8'h01, {7'h00, strap_done});
    rd(8'h4F, rv);
    chk("video_cfg", {6'h00, sel1[2], ~sel0[2]}, {6'h00, rv[7:6]});
    rd(8'hC2, rv);
    chk("repeater", {7'h00, sel0[0]}, {7'h00, rv[5]});
    rd(8'h5B, rv);
    chk("cable", {7'h00, sel1[1]}, {7'h00, rv[7]});
    chk("outs", {4'h0, sel0[2], sel0[0], sel1[2], sel1[1]},
        {4'h0, dual_pixel_mode, repeater_en, bit_map_sel, cable_cable_type_strap});
    $display("test straps done");
    wr(8'h4F, {~sel1[2], sel0[2], 6'h00});
    wr(8'hC2, {2'h0, ~sel0[0], 5'h00});
    wr(8'h5B, {~sel1[1], 7'h00});
    rd(8'h4F, rv);
    chk("video_cfg_wr", {~sel1[2], sel0[2], 6'h00}, rv & 8'hC0);
    chk("outs_wr", {4'h0, ~sel0[2], ~sel0[0], ~sel1[2], ~sel1[1]},
        {4'h0, dual_pixel_mode, repeater_en, bit_map_sel, cable_cable_type_strap});
    rd(8'h10, rv);
    chk("unmapped", 8'h00, rv);
    $display("test overwrite done");
    for (int k = 0; k < 4; k++)
    begin
      seed = xs(seed);
      wr(8'h66, {3'h0, seed[4:0]});
      wr(8'h67, seed[15:8]);
      wr(8'h66, {3'h7, seed[4:0]});
      cyc(2);
      rd(8'h67, rv);
      chk("pat_data", seed[15:8], rv);
    end
    $display("test indirect done");
    for (int k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      {ent[2 * k + 1], ent[2 * k]} = seed[7:0];
      wr(8'h70 + 8'(k), seed[7:0]);
    end
    wr(8'h68, 8'hF1);
    cyc(3);
    for (int k = 1; k <= 17; k++)
    begin
      chk("pattern_sel", {4'h0, ent[(k - 1) % 16]}, {4'h0, pattern_sel});
      frame_start = 1'b1;
      cyc(1);
      frame_start = 1'b0;
      cyc(3);
    end
    wr(8'h64, {4'h0, seed[11:8]});
    wr(8'h68, 8'h00);
    cyc(3);
    chk("static_pat", {4'h0, seed[11:8]}, {4'h0, pattern_sel});
    $display("test scroll done");
    wr(8'h5B, 8'h00);
    auto(2'h3, 1'b0, 1'b0);
    chk("second_core", 8'h01, {7'h00, cipher_second_core_en});
    auto(2'h2, 1'b0, 1'b0);
    chk("video_en", 8'h01, {6'h00, link0_video_en, link1_video_en});
    auto(2'h1, 1'b0, 1'b0);
    auto(2'h3, 1'b1, 1'b0);
    pclk_run = 1'b1;
    cyc(9000);
    auto(2'h3, 1'b1, 1'b1);
    chk("dual_flags", 8'h0F, {4'h0, tx_half_rate, cipher_joint_session,
        link0_video_en, link1_video_en});
    rd(8'h7F, rv);
    chk("status", 8'h22, rv);
    auto(2'h1, 1'b0, 1'b1);
    $display("test auto done");
    wr(8'h5B, 8'h04);
    chk("forced_single", 8'h01, {4'h0, link_mode});
    chk("single_flags", 8'h06, {5'h00, tx1_power_down, bc1_disable, link1_video_en});
    wr(8'h5B, 8'h05);
    chk("forced_dual", 8'h02, {4'h0, link_mode});
    ce = 1'b0;
    wr(8'h5B, 8'h04);
    chk("ce_freeze", 8'h02, {4'h0, link_mode});
    ce = 1'b1;
    $display("test forced done");
    end_of_test();
  end
endmodule
